// ==== pkg/wtc_defines.svh ====
`ifndef WTC_DEFINES_SVH
`define WTC_DEFINES_SVH

// byte offsets of the low byte of each configuration register
`define WTC_OFF_UV 12'h600
`define WTC_OFF_OV 12'h602
`define WTC_OFF_TREC 12'h604
`define WTC_OFF_TTRIP 12'h606
`define WTC_OFF_MINPER 12'h608
`define WTC_OFF_PINGPER 12'h60C
`define WTC_OFF_APDCNT 12'h610
`define WTC_OFF_ILIM 12'h614
`define WTC_OFF_RXTHR 12'h61A
`define WTC_OFF_SPACING 12'h624
`define WTC_OFF_OCDIS 12'h83A
// block-local status registers
`define WTC_OFF_INT_STAT 12'h640
`define WTC_OFF_INT_MASK 12'h641
`define WTC_OFF_TX_CODE 12'h642
`define WTC_OFF_FLAGS 12'h643

// reset values
`define WTC_RST_UV 16'h109A
`define WTC_RST_OV 16'h3E80
`define WTC_RST_TREC 16'h0600
`define WTC_RST_TTRIP 16'h0440
`define WTC_RST_MINPER 16'h0222
`define WTC_RST_PINGPER 16'h019B
`define WTC_RST_APDCNT 16'h000A
`define WTC_RST_ILIM 16'h0929
`define WTC_RST_RXTHR 16'h0030
`define WTC_RST_SPACING 16'h012C
`define WTC_RST_OCDIS 16'h0000

// register table size and the index that means no hit
`define WTC_NREG 11
`define WTC_IDX_NONE 4'hF

// interrupt status bit positions
`define WTC_EV_UV 0
`define WTC_EV_OV 1
`define WTC_EV_THERM 2
`define WTC_EV_OC 3
`define WTC_EV_RXDET 4
`define WTC_EV_DPING 5
`define WTC_NEV 6

// transmitter status codes
`define WTC_CODE_OK 8'h00
`define WTC_CODE_OT 8'h06
`define WTC_CODE_OC 8'h07
`define WTC_CODE_WIN 8'h0C
`define WTC_CODE_LOCKOUT 8'h0D

// timing
`define WTC_CLK_NS 10
`define WTC_MS_NS 1000000

`endif

// ==== pkg/wtc_pkg.sv ====
`include "wtc_defines.svh"

package wtc_pkg;

  // ping sequencer states, one-hot
  typedef enum logic [2:0] {
    WTC_WAIT = 3'h1,
    WTC_RESP = 3'h2,
    WTC_DPING = 3'h4
  } wtc_ping_t;

  // whole state of the register bank
  typedef struct packed {
    logic [`WTC_NREG-1:0][15:0] cfg;
    logic [`WTC_NEV-1:0] ists;
    logic [`WTC_NEV-1:0] imask;
    logic irq;
    logic [7:0] rdata;
    logic uv;
    logic ov;
    logic therm;
    logic oc;
    logic [7:0] code;
    wtc_ping_t ps;
    logic [15:0] ms_cnt;
    logic [7:0] ap_cnt;
    logic aping;
    logic dping;
    logic rx_present;
    logic [15:0] op_period;
  } wtc_state_t;

  // state of the tick divider
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } wtc_div_t;

endpackage

// ==== src/wtc_tick_div.sv ====
`timescale 1ns/1ps

// free-running divider: one-cycle tick every DIV clocks
module wtc_tick_div
  import wtc_pkg::*;
#(
  parameter int unsigned DIV = 100000
) (
  input wire logic mclk,
  input wire logic rst_b,
  output logic tick
);

  wtc_div_t div_ff; // count and tick
  wtc_div_t nxt_div; // next value

  // count up, wrap and pulse at the end of each period
  always_comb begin
    nxt_div = div_ff;
    nxt_div.tick = 1'b0;
    if (div_ff.cnt >= DIV - 1) begin
      nxt_div.cnt = 32'h0;
      nxt_div.tick = 1'b1;
    end else begin
      nxt_div.cnt = div_ff.cnt + 32'h1;
    end
  end

  // synchronous active-low reset
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      div_ff <= '0;
    end else begin
      div_ff <= nxt_div;
    end
  end

  assign tick = div_ff.tick;

endmodule

// ==== src/wtc_cfg_regs.sv ====
`timescale 1ns/1ps
`include "wtc_defines.svh"

// What this block does
// - hold under-voltage threshold, detect low supply
// - hold over-voltage threshold, detect high supply
// - thermal trip when thermistor count below trip
// - thermal recover only above recovery threshold
// - over-current trip above milliamp limit
// - guard disable: zero protects, one disables
// - digital ping uses stored period count
// - set number of analog pings per digital
// - analog response compared to detect threshold
// - analog pings spaced by millisecond interval
// - operating period clamped to minimum-frequency limit
// - window fault code 12, lockout code 13
// - thermal code 6, over-current code 7
module wtc_cfg_regs
  import wtc_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `WTC_MS_NS / `WTC_CLK_NS
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic meas_valid,
  input wire logic [15:0] vin_mv,
  input wire logic [15:0] ntc_adc,
  input wire logic [15:0] iin_ma,
  input wire logic aping_resp_valid,
  input wire logic [7:0] aping_resp_level,
  input wire logic [15:0] req_period,
  output logic aping_start,
  output logic dping_start,
  output logic [15:0] dping_period,
  output logic [15:0] op_period,
  output logic [7:0] tx_status_code,
  output logic power_inhibit,
  output logic rx_present,
  output logic irq
);

  // register map, byte addressed, 16-bit values split over two bytes:
  //   0x600/0x601 under-voltage threshold, default 0x109A
  //   0x602/0x603 over-voltage threshold, default 0x3E80
  //   0x604/0x605 thermal recovery threshold, default 0x0600
  //   0x606/0x607 thermal trip threshold, default 0x0440
  //   0x608/0x609 minimum-frequency period limit, default 0x0222
  //   0x60C/0x60D digital ping period, default 0x019B
  //   0x610 analog pings per digital ping, byte wide, default 0x0A
  //   0x614/0x615 input current limit in mA, default 0x0929
  //   0x61A receiver detect threshold, byte wide, default 0x30
  //   0x624/0x625 analog ping spacing in ms, default 0x012C
  //   0x83A current guard disable, byte wide, default 0x00
  // the two bytes of a wide value are not latched together, so software
  // that changes both halves sees a mixed value from the first byte write until the second
  // register index map, shared by read and write decode
  function automatic logic [3:0] wtc_find(input logic [11:0] a);
    logic [3:0] r;
    r = `WTC_IDX_NONE;
    case ({a[11:1], 1'b0})
      `WTC_OFF_UV: r = 4'h0;
      `WTC_OFF_OV: r = 4'h1;
      `WTC_OFF_TREC: r = 4'h2;
      `WTC_OFF_TTRIP: r = 4'h3;
      `WTC_OFF_MINPER: r = 4'h4;
      `WTC_OFF_PINGPER: r = 4'h5;
      `WTC_OFF_APDCNT: r = 4'h6;
      `WTC_OFF_ILIM: r = 4'h7;
      `WTC_OFF_RXTHR: r = 4'h8;
      `WTC_OFF_SPACING: r = 4'h9;
      `WTC_OFF_OCDIS: r = 4'hA;
      default: r = `WTC_IDX_NONE;
    endcase
    // byte-wide registers have no odd byte
    if (a[0] && (r == 4'h6 || r == 4'h8 || r == 4'hA)) begin
      r = `WTC_IDX_NONE;
    end
    return r;
  endfunction

  // default value per index
  function automatic logic [15:0] wtc_rst_val(input int i);
    logic [15:0] v;
    v = 16'h0000;
    case (i)
      0: v = `WTC_RST_UV;
      1: v = `WTC_RST_OV;
      2: v = `WTC_RST_TREC;
      3: v = `WTC_RST_TTRIP;
      4: v = `WTC_RST_MINPER;
      5: v = `WTC_RST_PINGPER;
      6: v = `WTC_RST_APDCNT;
      7: v = `WTC_RST_ILIM;
      8: v = `WTC_RST_RXTHR;
      9: v = `WTC_RST_SPACING;
      10: v = `WTC_RST_OCDIS;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  // complete reset image of the state
  function automatic wtc_state_t wtc_rst_state();
    wtc_state_t s;
    s = '0;
    for (int i = 0; i < `WTC_NREG; i++) begin
      s.cfg[i] = wtc_rst_val(i);
    end
    s.ps = WTC_WAIT;
    s.code = `WTC_CODE_OK;
    s.op_period = `WTC_RST_MINPER;
    return s;
  endfunction

  // all state but the ms divider's lives in one packed struct: the comb block below fills
  // nxt_st field by field and the single flop stage registers it whole
  wtc_state_t st_ff; // registered state
  wtc_state_t nxt_st; // next state
  logic tick_ms; // one-cycle millisecond enable
  logic [3:0] idx; // decoded register index
  logic [`WTC_NEV-1:0] ev; // events this cycle
  logic [`WTC_NEV-1:0] w1c; // bits software clears
  logic oc_en; // guard active
  logic ap_hit; // analog response at or above threshold
  logic ap_done; // analog ping window closed
  logic [15:0] spacing; // spacing, never below one ms

  // millisecond time base for ping spacing
  wtc_tick_div #(
    .DIV(MS_CYCLES)
  ) u_ms (
    .mclk(mclk),
    .rst_b(rst_b),
    .tick(tick_ms)
  );

  // register index of a read or write into the table
  assign idx = wtc_find(reg_addr);

  // any nonzero guard disable value turns the guard off
  assign oc_en = (st_ff.cfg[10][7:0] == 8'h00);

  // a zero spacing would stall, so treat it as one ms
  assign spacing = (st_ff.cfg[9] == 16'h0000) ? 16'h0001 : st_ff.cfg[9];

  // presence decision on each analog response
  assign ap_hit = aping_resp_level >= st_ff.cfg[8][7:0];

  // response or a full ms without one ends the window
  assign ap_done = aping_resp_valid || tick_ms;

  // interrupt status layout, shared by the mask register:
  //   bit 0 under-voltage, bit 1 over-voltage, bit 2 thermal trip,
  //   bit 3 over-current, bit 4 receiver newly detected,
  //   bit 5 digital ping launched
  // each bit is set on the rising edge of its event and cleared by
  // writing a one; an event in the clearing cycle keeps the bit set, so
  // software never loses an edge that races its own clear
  // software clear mask for the sticky bits
  assign w1c = (reg_wr && reg_addr == `WTC_OFF_INT_STAT) ?
               reg_wdata[`WTC_NEV-1:0] : '0;

  // all next-state logic
  always_comb begin
    nxt_st = st_ff;
    ev = '0;
    nxt_st.rdata = 8'h00;
    nxt_st.aping = 1'b0;
    nxt_st.dping = 1'b0;

    // writes: low byte at even, high byte at odd address
    if (reg_wr && idx != `WTC_IDX_NONE) begin
      if (reg_addr[0]) begin
        nxt_st.cfg[idx][15:8] = reg_wdata;
      end else begin
        nxt_st.cfg[idx][7:0] = reg_wdata;
      end
    end
    // mask register write
    if (reg_wr && reg_addr == `WTC_OFF_INT_MASK) begin
      nxt_st.imask = reg_wdata[`WTC_NEV-1:0];
    end

    // reads return data one cycle later, zero when unmapped
    if (reg_rd) begin
      if (idx != `WTC_IDX_NONE) begin
        nxt_st.rdata = reg_addr[0] ? st_ff.cfg[idx][15:8] :
                       st_ff.cfg[idx][7:0];
      end else begin
        case (reg_addr)
          `WTC_OFF_INT_STAT: nxt_st.rdata = {2'b00, st_ff.ists};
          `WTC_OFF_INT_MASK: nxt_st.rdata = {2'b00, st_ff.imask};
          `WTC_OFF_TX_CODE: nxt_st.rdata = st_ff.code;
          `WTC_OFF_FLAGS: begin
            nxt_st.rdata = {3'b000, st_ff.rx_present, st_ff.oc,
                            st_ff.therm, st_ff.ov, st_ff.uv};
          end
          default: nxt_st.rdata = 8'h00;
        endcase
      end
    end

    // fault flags follow the measurement strobe; between strobes they
    // hold, so register writes never flip a flag, except a guard disable write clearing over-current
    // compares are strict on purpose: a value sitting exactly on a threshold
    // is treated as good, except that a thermal trip holds at the recovery threshold; this keeps a quiet input from chattering
    // the thermal flag has hysteresis: once set it stays until the
    // thermistor count climbs above the recovery threshold
    // protection runs on each new measurement, with current thresholds
    if (meas_valid) begin
      nxt_st.uv = vin_mv < st_ff.cfg[0];
      nxt_st.ov = vin_mv > st_ff.cfg[1];
      // hysteresis: trip low, release only above recovery
      if (!st_ff.therm) begin
        nxt_st.therm = ntc_adc < st_ff.cfg[3];
      end else begin
        nxt_st.therm = !(ntc_adc > st_ff.cfg[2]);
      end
      nxt_st.oc = oc_en && (iin_ma > st_ff.cfg[7]);
    end
    // disabling the guard drops a standing over-current at once
    if (!oc_en) begin
      nxt_st.oc = 1'b0;
    end

    // only new faults raise events, so a fault that stands across many
    // measurements interrupts once
    // rising edges of each fault are interrupt events
    ev[`WTC_EV_UV] = nxt_st.uv && !st_ff.uv;
    ev[`WTC_EV_OV] = nxt_st.ov && !st_ff.ov;
    ev[`WTC_EV_THERM] = nxt_st.therm && !st_ff.therm;
    ev[`WTC_EV_OC] = nxt_st.oc && !st_ff.oc;

    // one code at a time: the latched thermal fault outranks the rest, and
    // under-voltage outranks over-voltage should both ever stand together
    // status code, thermal first since it latches
    if (nxt_st.therm) begin
      nxt_st.code = `WTC_CODE_OT;
    end else if (nxt_st.oc) begin
      nxt_st.code = `WTC_CODE_OC;
    end else if (nxt_st.uv) begin
      nxt_st.code = `WTC_CODE_LOCKOUT;
    end else if (nxt_st.ov) begin
      nxt_st.code = `WTC_CODE_WIN;
    end else begin
      nxt_st.code = `WTC_CODE_OK;
    end

    // a longer period means a lower frequency, so the limit is a ceiling
    // on the period count; the request is used one cycle after it arrives
    // request clamped so frequency never falls below the minimum
    if (req_period > st_ff.cfg[4]) begin
      nxt_st.op_period = st_ff.cfg[4];
    end else begin
      nxt_st.op_period = req_period;
    end

    // ping sequencer: wait the programmed number of ms ticks, launch an
    // analog ping, then wait for the receiver's answer or one more tick;
    // after the programmed number of analog pings a digital ping follows
    // a count of zero acts as one, since a zero would never reach the end
    // any fault sends it back to waiting with its counts cleared, so a
    // recovered supply restarts a full spacing rather than a partial one
    // a response that arrives outside the answer window is dropped, since
    // only the answer state looks at the response strobe
    // ping sequencer, held idle while any fault stands
    if (st_ff.uv || st_ff.ov || st_ff.therm || st_ff.oc) begin
      nxt_st.ps = WTC_WAIT;
      nxt_st.ms_cnt = 16'h0000;
      nxt_st.ap_cnt = 8'h00;
    end else begin
      case (st_ff.ps)
        // count whole ms between analog pings
        WTC_WAIT: begin
          if (tick_ms) begin
            if (st_ff.ms_cnt + 16'h1 >= spacing) begin
              nxt_st.ms_cnt = 16'h0000;
              nxt_st.aping = 1'b1;
              nxt_st.ps = WTC_RESP;
            end else begin
              nxt_st.ms_cnt = st_ff.ms_cnt + 16'h1;
            end
          end
        end
        // wait for the analog response or give up after a ms
        WTC_RESP: begin
          if (ap_done) begin
            if (aping_resp_valid && ap_hit) begin
              nxt_st.rx_present = 1'b1;
              ev[`WTC_EV_RXDET] = !st_ff.rx_present;
            end else begin
              nxt_st.rx_present = 1'b0;
            end
            // enough analog pings: go for the digital one
            if (st_ff.ap_cnt + 8'h1 >= st_ff.cfg[6][7:0]) begin
              nxt_st.ap_cnt = 8'h00;
              nxt_st.ps = WTC_DPING;
            end else begin
              nxt_st.ap_cnt = st_ff.ap_cnt + 8'h1;
              nxt_st.ps = WTC_WAIT;
            end
          end
        end
        // one-cycle digital ping start at the stored period
        WTC_DPING: begin
          nxt_st.dping = 1'b1;
          ev[`WTC_EV_DPING] = 1'b1;
          nxt_st.ps = WTC_WAIT;
        end
        default: begin
          nxt_st.ps = WTC_WAIT;
        end
      endcase
    end

    // sticky status: a set in the clearing cycle wins
    nxt_st.ists = (st_ff.ists & ~w1c) | ev;
    nxt_st.irq = |(nxt_st.ists & nxt_st.imask);
  end

  // one register for all state outside the ms divider keeps reset and update in one place;
  // the reset image comes from a function so defaults live in one spot
  // single state register, synchronous active-low reset
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_ff <= wtc_rst_state();
    end else begin
      st_ff <= nxt_st;
    end
  end

  // every output below is a flop or a plain OR of flops, so nothing
  // combinational from the bus or the measurement inputs reaches the pins
  // outputs straight from the state flops
  assign reg_rdata = st_ff.rdata;
  assign aping_start = st_ff.aping;
  assign dping_start = st_ff.dping;
  assign dping_period = st_ff.cfg[5];
  assign op_period = st_ff.op_period;
  assign tx_status_code = st_ff.code;
  assign power_inhibit = st_ff.uv | st_ff.ov | st_ff.therm | st_ff.oc;
  assign rx_present = st_ff.rx_present;
  assign irq = st_ff.irq;

endmodule

// ==== tb/wtc_rx_model.sv ====
`timescale 1ns/1ps

// receiver on the coil: answers each analog ping rx_dly + 1 cycles after its start pulse
module wtc_rx_model (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic aping_start,
  input wire logic [7:0] rx_lvl,
  input wire logic [7:0] rx_dly,
  output logic aping_resp_valid,
  output logic [7:0] aping_resp_level
);
  int cnt = 0; // cycles to the answer, 0 when idle
  initial aping_resp_valid = 1'b0;
  initial aping_resp_level = 8'h5A;
  // between answers the level line toggles, so a stale level never passes
  always @(posedge mclk) begin
    aping_resp_valid <= 1'b0;
    aping_resp_level <= ~aping_resp_level;
    if (!rst_b) begin
      cnt <= 0;
    end else if (aping_start) begin
      cnt <= rx_dly + 1;
    end else if (cnt == 1) begin
      // coupled receiver shows its level for one cycle
      cnt <= 0;
      aping_resp_valid <= 1'b1;
      aping_resp_level <= rx_lvl;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// ==== tb/wtc_cfg_regs_chk.sv ====
`timescale 1ns/1ps

// port-level checks of the configuration bank
module wtc_cfg_regs_chk (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_rdata,
  input wire logic meas_valid,
  input wire logic [15:0] req_period,
  input wire logic aping_start,
  input wire logic dping_start,
  input wire logic [15:0] dping_period,
  input wire logic [15:0] op_period,
  input wire logic [7:0] tx_status_code,
  input wire logic power_inhibit
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  AST_INHIBIT_CODE: assert property (power_inhibit == (tx_status_code != 8'h00))
    else $error("inhibit and status code disagree");
  AST_CODE_LEGAL: assert property (tx_status_code inside {8'h00, 8'h06, 8'h07, 8'h0C, 8'h0D})
    else $error("unknown status code");
  // a thermal trip only moves on a new measurement
  AST_THERM_HOLD: assert property (tx_status_code == 8'h06 && !meas_valid |=> $stable(tx_status_code))
    else $error("thermal code left without measurement");
  AST_APING_PULSE: assert property (aping_start |=> !aping_start)
    else $error("analog ping start too long");
  AST_DPING_PULSE: assert property (dping_start |-> !aping_start ##1 !dping_start)
    else $error("digital ping start malformed");
  // the pause of one cycle covers a fault landing beside a launch
  AST_NO_PING: assert property ($past(power_inhibit) && power_inhibit |-> !aping_start && !dping_start)
    else $error("ping while inhibited");
  AST_OP_CLAMP: assert property ($past(rst_b) |-> op_period <= $past(req_period))
    else $error("operating period above request");
  AST_DPERIOD: assert property (!$past(reg_wr) && !$past(reg_wr, 2) |-> $stable(dping_period))
    else $error("ping period moved without a write");
endmodule

// ==== tb/wtc_cfg_regs_bench.sv ====
`timescale 1ns/1ps

`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end

module wtc_cfg_regs_bench;
  localparam int MS = 20; // short millisecond keeps the ping walk brief
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic meas_valid = 1'b0;
  logic [15:0] vin_mv = 16'h0000, ntc_adc = 16'h0000, iin_ma = 16'h0000;
  logic [15:0] req_period = 16'hFFFF; // above the limit so reset leaves no clamp hazard
  logic [7:0] rx_lvl = 8'h30;
  logic [7:0] rx_dly = 8'h03;
  logic aping_resp_valid, aping_start, dping_start, power_inhibit, rx_present, irq;
  logic [7:0] aping_resp_level, reg_rdata, tx_status_code, d;
  logic [15:0] dping_period, op_period, w;
  logic th = 1'b0; // expected thermal latch
  logic ocdis = 1'b0; // guard disable as last written
  logic [7:0] ec; // expected status code
  int err_count = 0, n_tests = 0, na, nd, ta;
  logic [11:0] offs [11] = '{12'h600, 12'h602, 12'h604, 12'h606, 12'h608, 12'h60C,
    12'h610, 12'h614, 12'h61A, 12'h624, 12'h83A};
  logic [15:0] rsts [11] = '{16'h109A, 16'h3E80, 16'h0600, 16'h0440, 16'h0222, 16'h019B,
    16'h000A, 16'h0929, 16'h0030, 16'h012C, 16'h0000};

  wtc_cfg_regs #(.MS_CYCLES(MS)) i_dut (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .meas_valid, .vin_mv, .ntc_adc, .iin_ma, .aping_resp_valid,
    .aping_resp_level, .req_period, .aping_start, .dping_start, .dping_period, .op_period,
    .tx_status_code, .power_inhibit, .rx_present, .irq);
  wtc_rx_model i_rx (.mclk, .rst_b, .aping_start, .rx_lvl, .rx_dly, .aping_resp_valid,
    .aping_resp_level);

  initial begin
    forever #5 mclk = ~mclk;
  end

  // register bus cycles, one strobe cycle each
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // priority thermal, over-current, lockout, window
  function automatic logic [7:0] exp_code(input logic [15:0] v, input logic [15:0] i);
    if (th) return 8'h06;
    if (!ocdis && i > 16'h0929) return 8'h07;
    if (v < 16'h109A) return 8'h0D;
    if (v > 16'h3E80) return 8'h0C;
    return 8'h00;
  endfunction

  // one measurement with a fresh period request, checked a cycle later
  task automatic meas(input logic [15:0] v, input logic [15:0] n, input logic [15:0] i);
    @(posedge mclk);
    meas_valid <= 1'b1;
    vin_mv <= v;
    ntc_adc <= n;
    iin_ma <= i;
    req_period <= 16'($urandom);
    th = (n < 16'h0440) ? 1'b1 : (n > 16'h0600) ? 1'b0 : th;
    ec = exp_code(v, i);
    @(posedge mclk);
    meas_valid <= 1'b0;
    #1;
    `CHK(tx_status_code, ec)
    `CHK(power_inhibit, ec != 8'h00)
    `CHK(op_period, (req_period < 16'h0222) ? req_period : 16'h0222)
  endtask

  task automatic complete_run();
    $display("mismatches %0d of %0d checks", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    w = 16'($urandom(32'hBCEA369A));
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    // defaults, then a random pattern per register, then defaults back
    for (int r = 0; r < 11; r++) begin
      w = 16'($urandom);
      rd(offs[r], d);
      `CHK(d, rsts[r][7:0])
      rd(offs[r] + 12'h001, d);
      `CHK(d, rsts[r][15:8])
      wr(offs[r], w[7:0]);
      wr(offs[r] + 12'h001, w[15:8]);
      rd(offs[r], d);
      `CHK(d, w[7:0])
      rd(offs[r] + 12'h001, d);
      `CHK(d, (offs[r] inside {12'h610, 12'h61A, 12'h83A}) ? 8'h00 : w[15:8])
      wr(offs[r], rsts[r][7:0]);
      wr(offs[r] + 12'h001, rsts[r][15:8]);
    end
    `CHK(dping_period, 16'h019B)
    wr(12'h642, 8'hFF); // read-only code ignores the write
    rd(12'h642, d);
    `CHK(d, 8'h00)
    rd(12'h6FF, d);
    `CHK(d, 8'h00)
    meas(16'h109A, 16'h0440, 16'h0929); // every input exactly at its threshold
    meas(16'h3E81, 16'h0600, 16'h092A); // voltage and current one step past, thermistor at recovery
    for (int k = 0; k < 200; k++) begin
      if (k == 100) begin
        wr(12'h83A, 8'h01);
        ocdis = 1'b1;
      end
      meas(16'h1000 + 16'($urandom % 32'h3000), 16'h0400 + 16'($urandom % 32'h0240),
        16'h0900 + 16'($urandom % 32'h0040));
    end
    wr(12'h83A, 8'h00);
    ocdis = 1'b0;
    // interrupt: raise, mask, clear
    meas(16'h2000, 16'h0700, 16'h0100);
    wr(12'h640, 8'h3F);
    wr(12'h641, 8'h01);
    @(posedge mclk);
    #1 `CHK(irq, 1'b0)
    meas(16'h1000, 16'h0700, 16'h0100);
    `CHK(irq, 1'b1)
    rd(12'h640, d);
    `CHK(d[0], 1'b1)
    rd(12'h643, d);
    `CHK(d[3:0], 4'h1)
    wr(12'h641, 8'h00);
    @(posedge mclk);
    #1 `CHK(irq, 1'b0)
    wr(12'h641, 8'h01);
    wr(12'h640, 8'h01);
    @(posedge mclk);
    #1 `CHK(irq, 1'b0)
    // ping walk: two analog pings, two ms apart, per digital ping
    meas(16'h2000, 16'h0700, 16'h0100);
    wr(12'h624, 8'h02);
    wr(12'h625, 8'h00);
    wr(12'h610, 8'h02);
    for (int p = 0; p < 2; p++) begin
      rx_lvl <= 8'h30 - 8'(p); // at the threshold, then one below
      na = 0;
      nd = 0;
      ta = 0;
      for (int k = 0; k < 3000 && nd < 2; k++) begin
        @(posedge mclk);
        #1;
        if (dping_start) nd++;
        if (aping_start && nd == 1) begin
          if (na > 0) `CHK(k - ta inside {[MS + 1 : 3 * MS + 10]}, 1'b1)
          na++;
          ta = k;
        end
      end
      if (nd < 2) begin
        err_count++;
        break;
      end
      `CHK(na, 2)
      `CHK(rx_present, p == 0)
    end
    rd(12'h640, d);
    `CHK(d[5], 1'b1)
    complete_run();
  end
endmodule

bind wtc_cfg_regs wtc_cfg_regs_chk i_chk (.mclk, .rst_b, .reg_rd, .reg_wr, .reg_rdata,
  .meas_valid, .req_period, .aping_start, .dping_start, .dping_period, .op_period,
  .tx_status_code, .power_inhibit);
